/* File: rtl/ncr_pkg.sv */
// Purpose: constants for the nc command data register bank
// Assumes: 16-bit word registers, two part systems
// Notes:   word indices double as bus addresses
// What this block does
// [R1] auto speed word waits finish or gear done
// [R2] manual speed input waits the same
// [R3] reset and stop never clear speed word
// [R4] surface speed mode loads surface speed value
// [R5] speed word is plain binary rpm
// [R6] final word applies override, gear, stop, orient
// [R7] key monitor shows keys while pressed
// [R8] measured speed refreshed from encoder when present
// [R9] measured speed stored times one thousand
// [R10] misc code words are eight digit bcd
// [R11] misc slot one: auto, fixed cycle, manual
// [R12] independent misc code updates despite lock
// [R13] misc words held after finish and reset
// [R14] up to four misc codes, programmed order
// [R15] subprogram call and return codes hidden
// [R16] slots two to four only in auto
// [R17] spindle code words are plain binary
// [R18] spindle code words update, never cleared
// [R19] four spindle slots per system, fixed indices
// [R20] last spindle code in block wins
// [R21] tool code word is eight digit bcd
// [R22] two-word items read back atomically
package ncr_pkg;
  localparam logic [9:0]  SYS_STRIDE = 10'h0C8;
  localparam logic [9:0]  IDX_CMD    = 10'h008;
  localparam logic [9:0]  IDX_FINAL  = 10'h00A;
  localparam logic [9:0]  IDX_KEY    = 10'h010;
  localparam logic [9:0]  IDX_ACT    = 10'h012;
  localparam logic [9:0]  IDX_MCODE  = 10'h014;
  localparam logic [9:0]  IDX_SCODE  = 10'h01C;
  localparam logic [9:0]  IDX_TCODE  = 10'h024;
  localparam logic [9:0]  IDX_CFG    = 10'h180;
  localparam logic [9:0]  SLOT_SPAN  = 10'h008;
  localparam logic [31:0] CODE_CALL  = 32'h0000_0098;
  localparam logic [31:0] CODE_RET   = 32'h0000_0099;
  localparam logic [31:0] ACT_SCALE  = 32'h0000_03E8;
  localparam logic [39:0] OVR_DIV    = 40'h00_0000_0064;
  localparam logic [7:0]  OVR_RESET  = 8'h64;
  localparam logic [1:0]  MCNT_RESET = 2'h0;
  localparam int          CFG_OVR_MSB = 7;
  localparam int          CFG_CNT_LSB = 8;
  localparam int          CFG_CNT_MSB = 9;
  localparam logic [3:0][31:0] GEAR_TOP = {
    32'h0000_1F40, 32'h0000_1770, 32'h0000_0FA0, 32'h0000_07D0};
  typedef enum logic [1:0]
  {
    SRC_AUTO   = 2'b00,
    SRC_FIXED  = 2'b01,
    SRC_MANUAL = 2'b10
  } ncr_src_e;
endpackage

/* File: rtl/ncr_regs.sv */
// Purpose: read-only nc data words seen by the sequence program
// Assumes: core and sequence inputs share clk_sys
// Notes:   data words keep their value through sys_rst, except the key monitor, which sys_rst clears
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/10ps
module ncr_regs
  import ncr_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             ce,
  input  wire logic [9:0]       regAddr,
  input  wire logic [15:0]      regWdata,
  input  wire logic             regWrite,
  input  wire logic             regRead,
  output logic      [15:0]      regRdata,
  input  wire logic             sCmdValid,
  input  wire logic             sCmdSys,
  input  wire logic [1:0]       sCmdSlot,
  input  wire logic [31:0]      sCmdValue,
  input  wire logic [1:0]       misc_finish_one,
  input  wire logic [1:0]       misc_finish_two,
  input  wire logic [1:0]       gear_shift_done,
  input  wire logic [1:0]       cssActive,
  input  wire logic [1:0][31:0] cssValue,
  input  wire logic [1:0]       gear_select_in_a,
  input  wire logic [1:0]       gear_select_in_b,
  input  wire logic [1:0]       spindle_halt,
  input  wire logic [1:0]       spindle_gear_change,
  input  wire logic [1:0]       oriented_speed_cmd,
  input  wire logic [1:0][31:0] orientSpeed,
  input  wire logic [1:0][31:0] gearShiftSpeed,
  input  wire logic             keyValid,
  input  wire logic [15:0]      keyData,
  input  wire logic [1:0]       encoderPresent,
  input  wire logic [1:0][31:0] encoderSpeed,
  input  wire logic             mValid,
  input  wire logic             mSys,
  input  ncr_src_e              mSrc,
  input  wire logic [2:0]       mCount,
  input  wire logic [3:0][31:0] mCodes,
  input  wire logic             mIndependent,
  input  wire logic             mLock,
  input  wire logic             tValid,
  input  wire logic             tSys,
  input  wire logic [31:0]      tValue
);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------
  // storage
  // ---------------------------------------------
  logic [1:0][31:0]      cmdSpeed_q;
  logic [1:0][31:0]      finalCmd_q;
  logic [1:0][31:0]      measSpeed_q;
  logic [1:0][3:0][31:0] mSlot_q;
  logic [1:0][3:0][31:0] sSlot_q;
  logic [1:0][31:0]      tSlot_q;
  logic [15:0]           keyMon_q;
  logic [1:0]            pendValid_q;
  logic [1:0][31:0]      pendValue_q;
  logic [7:0]            ovr_q;
  logic [1:0]            mMax_q;
  logic [15:0]           hiSnap_q;
  logic                  upd;
  logic [1:0]            finAny;

  // data words except the key monitor stop changing while reset is held, never clear
  assign upd    = ce && !sys_rst;
  assign finAny = misc_finish_one | misc_finish_two | gear_shift_done;

  // ---------------------------------------------
  // configuration register
  // ---------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ovr_q  <= OVR_RESET;
      mMax_q <= MCNT_RESET;
    end
    else if (ce && regWrite && regAddr == IDX_CFG)
    begin
      ovr_q  <= regWdata[CFG_OVR_MSB:0];
      mMax_q <= regWdata[CFG_CNT_MSB:CFG_CNT_LSB];
    end
  end

  // ---------------------------------------------
  // commanded speed
  // ---------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pendValid_q <= '0;
    else if (ce)
    begin
      for (int s = 0; s < 2; s++)
      begin
        // a new command arriving with the finish stays pending
        if (sCmdValid && sCmdSys == s[0])
          pendValid_q[s] <= 1'b1;
        else if (finAny[s])
          pendValid_q[s] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (upd)
    begin
      for (int s = 0; s < 2; s++)
      begin
        // [R5] binary rpm held
        if (sCmdValid && sCmdSys == s[0])
          pendValue_q[s] <= sCmdValue;
        // [R4] surface speed first
        if (cssActive[s])
          cmdSpeed_q[s] <= cssValue[s];
        // [R1] [R2] finish gating
        else if (finAny[s] && pendValid_q[s])
          cmdSpeed_q[s] <= pendValue_q[s];
      end
    end
  end

  // ---------------------------------------------
  // final command
  // ---------------------------------------------
  logic [1:0][39:0] scaled;
  logic [1:0][39:0] topSpd;
  always_comb
  begin
    for (int s = 0; s < 2; s++)
    begin
      scaled[s] = (40'(cmdSpeed_q[s]) * 40'(ovr_q)) / OVR_DIV;
      topSpd[s] = 40'(GEAR_TOP[{gear_select_in_b[s],
                                gear_select_in_a[s]}]);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (upd)
    begin
      for (int s = 0; s < 2; s++)
      begin
        // [R6] stop, orient, shift, then clamp
        if (spindle_halt[s])
          finalCmd_q[s] <= '0;
        else if (oriented_speed_cmd[s])
          finalCmd_q[s] <= orientSpeed[s];
        else if (spindle_gear_change[s])
          finalCmd_q[s] <= gearShiftSpeed[s];
        else if (scaled[s] > topSpd[s])
          finalCmd_q[s] <= topSpd[s][31:0];
        else
          finalCmd_q[s] <= scaled[s][31:0];
      end
    end
  end

  // ---------------------------------------------
  // key monitor and measured speed
  // ---------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      keyMon_q <= '0;
    // [R7] keys while pressed
    else if (ce)
      keyMon_q <= keyValid ? keyData : '0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (upd)
    begin
      for (int s = 0; s < 2; s++)
      begin
        // [R8] [R9] scaled encoder feed
        if (encoderPresent[s])
          measSpeed_q[s] <= 32'(encoderSpeed[s] * ACT_SCALE);
      end
    end
  end

  // ---------------------------------------------
  // misc code slots
  // ---------------------------------------------
  logic [3:0][31:0] kept;
  logic [2:0]       nKept;
  logic [2:0]       lim;
  logic [3:0]       mWr;
  always_comb
  begin
    kept  = '0;
    nKept = '0;
    // [R15] drop subprogram codes
    // [R14] keep programmed order
    for (int i = 0; i < 4; i++)
    begin
      if (3'(i) < mCount && mCodes[i] != CODE_CALL
          && mCodes[i] != CODE_RET)
      begin
        kept[nKept[1:0]] = mCodes[i];
        nKept = nKept + 3'h1;
      end
    end
    // [R16] extra slots auto only
    lim = (mSrc == SRC_AUTO) ? 3'({1'b0, mMax_q}) + 3'h1 : 3'h1;
    // [R12] independent code passes lock
    for (int j = 0; j < 4; j++)
      mWr[j] = mValid && (!mLock || mIndependent)
               && 3'(j) < nKept && 3'(j) < lim;
  end

  always_ff @(posedge clk_sys)
  begin
    if (upd)
    begin
      // [R10] [R11] [R13] bcd slots held
      for (int j = 0; j < 4; j++)
        if (mWr[j])
          mSlot_q[mSys][j] <= kept[j];
      // [R18] [R20] [R17] last code wins
      if (sCmdValid)
        sSlot_q[sCmdSys][sCmdSlot] <= sCmdValue;
      // [R21] bcd tool code
      if (tValid)
        tSlot_q[tSys] <= tValue;
    end
  end

  // ---------------------------------------------
  // read port
  // ---------------------------------------------
  logic        sysSel;
  logic [9:0]  rel;
  logic [9:0]  mOff;
  logic [9:0]  sOff;
  logic [31:0] word;
  logic        hit;
  logic        isKey;
  always_comb
  begin
    sysSel = regAddr >= SYS_STRIDE;
    rel    = sysSel ? regAddr - SYS_STRIDE : regAddr;
    mOff   = rel - IDX_MCODE;
    sOff   = rel - IDX_SCODE;
    word   = '0;
    hit    = 1'b1;
    isKey  = !sysSel && rel == IDX_KEY;
    // [R19] slot index map
    if (rel[9:1] == IDX_CMD[9:1])
      word = cmdSpeed_q[sysSel];
    else if (rel[9:1] == IDX_FINAL[9:1])
      word = finalCmd_q[sysSel];
    else if (rel[9:1] == IDX_ACT[9:1])
      word = measSpeed_q[sysSel];
    else if (rel[9:1] == IDX_TCODE[9:1])
      word = tSlot_q[sysSel];
    else if (mOff < SLOT_SPAN)
      word = mSlot_q[sysSel][mOff[2:1]];
    else if (sOff < SLOT_SPAN)
      word = sSlot_q[sysSel][sOff[2:1]];
    else
      hit = 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      regRdata <= '0;
      hiSnap_q <= '0;
    end
    else if (ce && regRead)
    begin
      if (regAddr == IDX_CFG)
        regRdata <= 16'({mMax_q, ovr_q});
      else if (isKey)
        regRdata <= keyMon_q;
      // [R22] high half from snapshot
      else if (hit && !rel[0])
      begin
        regRdata <= word[15:0];
        hiSnap_q <= word[31:16];
      end
      else if (hit)
        regRdata <= hiSnap_q;
      else
        regRdata <= '0;
    end
  end

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  a_cmd_loads_pend: assert property ( // [R1]
    ce && finAny[0] && pendValid_q[0] && !cssActive[0]
    |=> cmdSpeed_q[0] == $past(pendValue_q[0]))
    else $error("speed word missed finish load");
  a_cmd_holds: assert property ( // [R2]
    ce && !finAny[0] && !cssActive[0] |=> $stable(cmdSpeed_q[0]))
    else $error("speed word changed without finish");
  a_cmd_survive_rst: assert property ( // [R3]
    $fell(sys_rst) |-> $stable(cmdSpeed_q[0]))
    else $error("speed word altered by reset");
  a_css_loads: assert property ( // [R4]
    ce && cssActive[0] |=> cmdSpeed_q[0] == $past(cssValue[0]))
    else $error("surface speed not loaded");
  a_final_halt: assert property ( // [R6]
    ce && spindle_halt[0] |=> finalCmd_q[0] == 32'h0000_0000)
    else $error("final word not zero on stop");
  a_key_view: assert property ( // [R7]
    ce && !keyValid |=> keyMon_q == 16'h0000)
    else $error("key monitor not cleared");
  a_meas_scale: assert property ( // [R9]
    ce && encoderPresent[0] |=> measSpeed_q[0]
    == 32'($past(encoderSpeed[0]) * ACT_SCALE))
    else $error("measured speed not scaled");
  a_lock_blocks: assert property ( // [R12]
    ce && mValid && mLock && !mIndependent
    |=> $stable(mSlot_q[$past(mSys)][0]))
    else $error("locked misc code updated");
  a_sub_hidden: assert property ( // [R15]
    ce && mWr[0] |=> mSlot_q[$past(mSys)][0] != CODE_CALL
    && mSlot_q[$past(mSys)][0] != CODE_RET)
    else $error("subprogram code shown");
  a_extra_auto: assert property ( // [R16]
    ce && mValid && mSrc != SRC_AUTO
    |=> $stable(mSlot_q[$past(mSys)][1]))
    else $error("slot two updated outside auto");
  a_scode_last: assert property ( // [R20]
    ce && sCmdValid |=> sSlot_q[$past(sCmdSys)][$past(sCmdSlot)]
    == $past(sCmdValue))
    else $error("spindle code not stored");
  a_snap_atomic: assert property ( // [R22]
    ce && regRead && regAddr == IDX_CMD ##1 !sCmdValid [*1]
    ##0 regRead && regAddr == IDX_CMD + 10'h001
    |=> regRdata == $past(cmdSpeed_q[0][31:16], 2))
    else $error("high half not from snapshot");

  c_finish_load: cover property (ce && finAny[0] && pendValid_q[0]);
  c_four_codes:  cover property (ce && mWr[3]);
  c_pair_read:   cover property (ce && regRead && regAddr == IDX_ACT
                                 ##1 regRead);
endmodule

/* File: verification/ncr_seq_model.sv */
// Purpose: stand-in for the sequence program answering spindle commands
// Assumes: one spindle command outstanding at a time
// Notes:   finish level is raised DLY cycles after the command, one cycle
`timescale 1ns/10ps
module ncr_seq_model
#(
  parameter int DLY = 3
)
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       sCmdValid,
  input  wire logic       sCmdSys,
  output logic      [1:0] finOne
);
  int   cnt;
  logic sysQ;

  initial finOne = 2'b00;

  // a slow answer, so the pending state is really held for a while
  always @(posedge clk_sys)
  begin
    finOne <= (!sys_rst && !sCmdValid && cnt == 1) ? (2'b01 << sysQ)
                                                   : 2'b00;
    if (sys_rst)
      cnt <= 0;
    else if (sCmdValid)
    begin
      cnt  <= DLY;
      sysQ <= sCmdSys;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule

/* File: verification/ncr_regs_bench.sv */
// Purpose: self-checking bench for the nc data register bank
// Assumes: reads return data the cycle after the strobe
// Notes:   power-up contents are unknown, so every check writes first
`timescale 1ns/10ps
module ncr_regs_bench;
  import ncr_pkg::*;
  typedef struct packed {logic s; logic [1:0] sl; logic [31:0] v;} ncr_row_s;
  logic clk_sys, sys_rst, ce, regWrite, regRead, sCmdValid, sCmdSys;
  logic keyValid, mValid, mIndependent, mLock, tValid;
  logic [9:0]       regAddr;
  logic [15:0]      regWdata, regRdata, keyData, rdat;
  logic [1:0]       sCmdSlot, finOne, zero2, cssActive, gearA, halt;
  logic [1:0]       shift, orient;
  logic [31:0]      sCmdValue, tValue;
  logic [1:0][31:0] cssValue, orientSpd, shiftSpd, encSpd;
  logic [3:0][31:0] mCodes, mExp;
  logic [2:0]       mCount;
  ncr_src_e         mSrc;
  int               err_total, n_tests, cycles, i;
  ncr_row_s rows[4] = '{'{1'b0, 2'd0, 32'd100}, '{1'b1, 2'd3, 32'd2500},
                        '{1'b0, 2'd2, 32'd900}, '{1'b0, 2'd0, 32'd1500}};

  ncr_regs ncr_regs_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .sCmdValid(sCmdValid),
    .sCmdSys(sCmdSys), .sCmdSlot(sCmdSlot), .sCmdValue(sCmdValue),
    .misc_finish_one(finOne), .misc_finish_two(zero2),
    .gear_shift_done(zero2), .cssActive(cssActive), .cssValue(cssValue),
    .gear_select_in_a(gearA), .gear_select_in_b(zero2),
    .spindle_halt(halt), .spindle_gear_change(shift),
    .oriented_speed_cmd(orient), .orientSpeed(orientSpd),
    .gearShiftSpeed(shiftSpd), .keyValid(keyValid), .keyData(keyData),
    .encoderPresent(2'b11), .encoderSpeed(encSpd), .mValid(mValid),
    .mSys(1'b0), .mSrc(mSrc), .mCount(mCount), .mCodes(mCodes),
    .mIndependent(mIndependent), .mLock(mLock), .tValid(tValid),
    .tSys(1'b0), .tValue(tValue));

  ncr_seq_model ncr_seq_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .sCmdValid(sCmdValid), .sCmdSys(sCmdSys), .finOne(finOne));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      give_verdict();
    end
  end

  task automatic chk32(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk16(string n, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd(logic [9:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic wr(logic [9:0] a, logic [15:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  // low half first, back to back, so the pair is one snapshot
  task automatic chkr(string n, logic [9:0] a, logic [31:0] e);
    logic [15:0] lo, hi;
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regAddr <= a + 10'h001;
    #1 lo = regRdata;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 hi = regRdata;
    chk32(n, e, {hi, lo});
  endtask

  task automatic mop(ncr_src_e s, logic [127:0] c, logic lk, logic ind);
    @(posedge clk_sys);
    {mValid, mSrc, mCount, mCodes, mLock, mIndependent} <= {1'b1, s, 3'd4,
      c, lk, ind};
    @(posedge clk_sys);
    mValid <= 1'b0;
  endtask

  initial
  begin
    {ce, sys_rst, keyData} = {1'b1, 1'b1, 16'h5A5A};
    {regWrite, regRead, regAddr, regWdata, sCmdValid, sCmdSys} = '0;
    {sCmdSlot, sCmdValue, zero2, cssActive, cssValue, gearA, halt} = '0;
    {shift, orient, orientSpd, shiftSpd, keyValid, mValid, mLock} = '0;
    {mIndependent, mCodes, mCount, tValid, tValue, encSpd} = '0;
    {err_total, n_tests, cycles} = '0;
    mSrc = SRC_AUTO;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    wr(IDX_CFG, 16'h0364);
    foreach (rows[i])
    begin
      @(posedge clk_sys);
      {sCmdValid, sCmdSys, sCmdSlot, sCmdValue} <= {1'b1, rows[i]};
      @(posedge clk_sys);
      sCmdValid <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chkr("scode", IDX_SCODE + 10'({rows[i].sl, 1'b0})
           + (rows[i].s ? SYS_STRIDE : 10'h000), rows[i].v);
    end
    chkr("cmd", IDX_CMD, 32'h0000_05DC);
    chkr("cmd2", IDX_CMD + SYS_STRIDE, 32'h0000_09C4);
    chkr("final", IDX_FINAL, 32'h0000_05DC);
    wr(IDX_CFG, 16'h03C8);
    chkr("final", IDX_FINAL, 32'h0000_07D0);
    @(posedge clk_sys);
    gearA <= 2'b01;
    chkr("final", IDX_FINAL, 32'h0000_0BB8);
    @(posedge clk_sys);
    {shift, shiftSpd[0]} <= {2'b01, 32'h0000_0037};
    chkr("final", IDX_FINAL, 32'h0000_0037);
    @(posedge clk_sys);
    {orient, orientSpd[0]} <= {2'b01, 32'h0000_0141};
    chkr("final", IDX_FINAL, 32'h0000_0141);
    @(posedge clk_sys);
    halt <= 2'b01;
    chkr("final", IDX_FINAL, 32'h0000_0000);
    @(posedge clk_sys);
    {keyValid, encSpd[0]} <= {1'b1, 32'h0000_0003};
    rd(IDX_KEY, rdat);
    chk16("key", 16'h5A5A, rdat);
    chkr("speed", IDX_ACT, 32'h0000_0BB8);
    @(posedge clk_sys);
    {keyValid, encSpd[0]} <= {1'b0, 32'h0000_0007};
    rd(IDX_KEY, rdat);
    chk16("key", 16'h0000, rdat);
    chkr("speed", IDX_ACT, 32'h0000_1B58);
    @(posedge clk_sys);
    {tValid, tValue} <= {1'b1, 32'h0012_3456};
    @(posedge clk_sys);
    tValid <= 1'b0;
    chkr("tcode", IDX_TCODE, 32'h0012_3456);
    mop(SRC_AUTO, {32'h4, 32'h3, 32'h2, 32'h1}, 1'b0, 1'b0);
    mop(SRC_AUTO, {32'h5, 32'h8, 32'h99, 32'h3}, 1'b0, 1'b0);
    mExp = {32'h4, 32'h5, 32'h8, 32'h3};
    for (i = 0; i < 4; i++)
      chkr("mcode", IDX_MCODE + 10'(2 * i), mExp[i]);
    mop(SRC_FIXED, 128'h42, 1'b0, 1'b0);
    chkr("mcode2", IDX_MCODE + 10'h002, 32'h0000_0008);
    chkr("mcode", IDX_MCODE, 32'h0000_0042);
    mop(SRC_MANUAL, 128'h43, 1'b0, 1'b0);
    chkr("mcode", IDX_MCODE, 32'h0000_0043);
    mop(SRC_AUTO, 128'h44, 1'b1, 1'b0);
    chkr("mcode", IDX_MCODE, 32'h0000_0043);
    mop(SRC_AUTO, 128'h45, 1'b1, 1'b1);
    chkr("mcode", IDX_MCODE, 32'h0000_0045);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    chkr("cmd", IDX_CMD, 32'h0000_05DC);
    chkr("mcode", IDX_MCODE, 32'h0000_0045);
    wr(IDX_CMD, 16'hFFFF);
    chkr("cmd", IDX_CMD, 32'h0000_05DC);
    rd(10'h3FF, rdat);
    chk16("unmapped", 16'h0000, rdat);
    @(posedge clk_sys);
    {cssActive, cssValue[0]} <= {2'b01, 32'h0000_0309};
    chkr("cmd", IDX_CMD, 32'h0000_0309);
    give_verdict();
  end
endmodule
